/* logic/isgl_regs.sv */
`timescale 1ns/1ps
// Operation
// - selector 0 first bus, 1 second bus, 2/3 test value; A 1:0, B 3:2
// - exponent-force bit set drives exponent 7 on both channels
// - hold bit keeps both integrators at their initial values
// - loop shift field for both channels; software writes 0 to 3 only
// - channel A amp code is inverted top three fixed-gain bits
// - channel B amp code is inverted top three fixed-gain bits
// - channel A readback returns top eight integrator magnitude bits
// - channel B readback returns top eight integrator magnitude bits
// - test value is 14-bit two's complement, low byte at lower address
module isgl_regs #(
    parameter int DW = 14,
    parameter int IW = 8
) (
    input wire logic REF_CLK_IN, // 10 MHz clock
    input wire logic RSTN_IN, // async reset, active low
    input wire logic [isgl_pkg::ISGL_ADDR_W-1:0] S_AXI_AWADDR_IN, // wr addr
    input wire logic S_AXI_AWVALID_IN, // wr addr valid
    output logic S_AXI_AWREADY_OUT, // wr addr ready
    input wire logic [31:0] S_AXI_WDATA_IN, // wr data
    input wire logic [3:0] S_AXI_WSTRB_IN, // byte strobes
    input wire logic S_AXI_WVALID_IN, // wr data valid
    output logic S_AXI_WREADY_OUT, // wr data ready
    output logic [1:0] S_AXI_BRESP_OUT, // wr response
    output logic S_AXI_BVALID_OUT, // wr response valid
    input wire logic S_AXI_BREADY_IN, // wr response ready
    input wire logic [isgl_pkg::ISGL_ADDR_W-1:0] S_AXI_ARADDR_IN, // rd addr
    input wire logic S_AXI_ARVALID_IN, // rd addr valid
    output logic S_AXI_ARREADY_OUT, // rd addr ready
    output logic [31:0] S_AXI_RDATA_OUT, // rd data
    output logic [1:0] S_AXI_RRESP_OUT, // rd response
    output logic S_AXI_RVALID_OUT, // rd data valid
    input wire logic S_AXI_RREADY_IN, // rd data ready
    input wire logic [DW-1:0] FIRST_INPUT_BUS_IN, // first input bus pins
    input wire logic [DW-1:0] SECOND_INPUT_BUS_IN, // second input bus pins
    input wire logic [3:0] EXP_A_IN, // computed exponent, channel A
    input wire logic [3:0] EXP_B_IN, // computed exponent, channel B
    input wire logic [IW-1:0] INTEG_A_IN, // integrator magnitude MSBs, A
    input wire logic [IW-1:0] INTEG_B_IN, // integrator magnitude MSBs, B
    input wire logic INTEG_UPD_IN, // integrator update strobe
    output logic [DW-1:0] CHAN_A_DATA_OUT, // channel A selected input
    output logic [DW-1:0] CHAN_B_DATA_OUT, // channel B selected input
    output logic [3:0] EXP_A_OUT, // exponent to float-to-fixed, A
    output logic [3:0] EXP_B_OUT, // exponent to float-to-fixed, B
    output logic INTEG_HOLD_OUT, // hold integrators at initial value
    output logic [1:0] LOOP_SHIFT_OUT, // gain loop shift
    output logic [7:0] INIT_A_OUT, // channel A initial condition
    output logic [7:0] INIT_B_OUT, // channel B initial condition
    output logic [2:0] AMP_A_GAIN_OUT, // external amp code, A
    output logic [2:0] AMP_B_GAIN_OUT // external amp code, B
);
    import isgl_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [DW-1:0] first_s1_q, first_s2_q, second_s1_q, second_s2_q;

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            first_s1_q <= '0;
            first_s2_q <= '0;
            second_s1_q <= '0;
            second_s2_q <= '0;
        end
        else
        begin
            first_s1_q <= FIRST_INPUT_BUS_IN;
            first_s2_q <= first_s1_q;
            second_s1_q <= SECOND_INPUT_BUS_IN;
            second_s2_q <= second_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [1:0] src_a_q, src_b_q;
    logic [7:0] ctrl_q, leg_lo_q, leg_hi_q, gain_a_q, gain_b_q;
    logic [13:0] test_q;
    logic [7:0] rb_a_q, rb_b_q;

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    logic aw_held_q, w_held_q, bvalid_q, awready_q, wready_q;
    logic [ISGL_ADDR_W-1:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic wstrb0_q;
    wire aw_take = S_AXI_AWVALID_IN && !aw_held_q && !bvalid_q;
    wire w_take = S_AXI_WVALID_IN && !w_held_q && !bvalid_q;
    wire [ISGL_ADDR_W-1:0] wa = aw_take ? S_AXI_AWADDR_IN : awaddr_q;
    wire [7:0] wd = w_take ? S_AXI_WDATA_IN[7:0] : wbyte_q;
    wire ws = w_take ? S_AXI_WSTRB_IN[0] : wstrb0_q;
    wire wr_go = (aw_take || aw_held_q) && (w_take || w_held_q) && !bvalid_q;
    wire [7:0] widx = wa[ISGL_ADDR_W-1:2];
    wire w_al = (wa[1:0] == 2'h0);
    wire wr_en = wr_go && ws && w_al;
    wire w_map = w_al && (widx >= ISGL_IDX_SOURCE) &&
                 (widx <= ISGL_IDX_TEST_HI);

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= '0;
            wbyte_q <= 8'h00;
            wstrb0_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            S_AXI_BRESP_OUT <= ISGL_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                awaddr_q <= S_AXI_AWADDR_IN;
            if (w_take)
            begin
                wbyte_q <= S_AXI_WDATA_IN[7:0];
                wstrb0_q <= S_AXI_WSTRB_IN[0];
            end
            if (wr_go)
            begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                awready_q <= 1'b0;
                wready_q <= 1'b0;
                S_AXI_BRESP_OUT <= w_map ? ISGL_RESP_OKAY : ISGL_RESP_SLVERR;
            end
            else
            begin
                aw_held_q <= aw_held_q | aw_take;
                w_held_q <= w_held_q | w_take;
                // readies reopen only when the write response is taken
                awready_q <= (awready_q & !aw_take) |
                             (bvalid_q & S_AXI_BREADY_IN);
                wready_q <= (wready_q & !w_take) |
                            (bvalid_q & S_AXI_BREADY_IN);
                if (bvalid_q && S_AXI_BREADY_IN)
                    bvalid_q <= 1'b0;
            end
        end
    end

    assign S_AXI_AWREADY_OUT = awready_q;
    assign S_AXI_WREADY_OUT = wready_q;
    assign S_AXI_BVALID_OUT = bvalid_q;

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            src_a_q <= ISGL_SRC_A_RST;
            src_b_q <= ISGL_SRC_B_RST;
            ctrl_q <= ISGL_CTRL_RST;
            leg_lo_q <= ISGL_BYTE_RST;
            leg_hi_q <= ISGL_BYTE_RST;
            gain_a_q <= ISGL_BYTE_RST;
            gain_b_q <= ISGL_BYTE_RST;
            test_q <= ISGL_TEST_RST;
        end
        else if (wr_en)
        begin
            case (widx)
                ISGL_IDX_SOURCE:
                begin
                    src_a_q <= wd[ISGL_SRC_A_LSB +: 2];
                    src_b_q <= wd[ISGL_SRC_B_LSB +: 2];
                end
                ISGL_IDX_CTRL: ctrl_q <= {2'h0, wd[5:0]};
                ISGL_IDX_LEGACY_LO: leg_lo_q <= wd;
                ISGL_IDX_LEGACY_HI: leg_hi_q <= wd;
                ISGL_IDX_GAIN_A: gain_a_q <= wd;
                ISGL_IDX_GAIN_B: gain_b_q <= wd;
                ISGL_IDX_TEST_LO: test_q[7:0] <= wd;
                ISGL_IDX_TEST_HI: test_q[13:8] <= wd[5:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // coherent readback capture
    // ----------------------------------------------------------------
    // whole bytes latched only on the update strobe, so a read sees one state
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            rb_a_q <= ISGL_BYTE_RST;
            rb_b_q <= ISGL_BYTE_RST;
        end
        else if (INTEG_UPD_IN)
        begin
            rb_a_q <= INTEG_A_IN[IW-1 -: 8];
            rb_b_q <= INTEG_B_IN[IW-1 -: 8];
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    logic rvalid_q, arready_q;
    wire ar_take = S_AXI_ARVALID_IN && !rvalid_q;
    wire [7:0] ridx = S_AXI_ARADDR_IN[ISGL_ADDR_W-1:2];
    wire r_al = (S_AXI_ARADDR_IN[1:0] == 2'h0);
    logic [7:0] rbyte;
    logic r_map;

    always_comb
    begin
        r_map = r_al;
        case (ridx)
            ISGL_IDX_SOURCE: rbyte = {4'h0, src_b_q, src_a_q};
            ISGL_IDX_CTRL: rbyte = ctrl_q;
            ISGL_IDX_LEGACY_LO: rbyte = leg_lo_q;
            ISGL_IDX_LEGACY_HI: rbyte = leg_hi_q;
            ISGL_IDX_GAIN_A: rbyte = gain_a_q;
            ISGL_IDX_GAIN_B: rbyte = gain_b_q;
            ISGL_IDX_RB_A: rbyte = rb_a_q;
            ISGL_IDX_RB_B: rbyte = rb_b_q;
            ISGL_IDX_TEST_LO: rbyte = test_q[7:0];
            ISGL_IDX_TEST_HI: rbyte = {2'h0, test_q[13:8]};
            default:
            begin
                rbyte = 8'h00;
                r_map = 1'b0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
            S_AXI_RDATA_OUT <= 32'h0000_0000;
            S_AXI_RRESP_OUT <= ISGL_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_q <= 1'b1;
            arready_q <= 1'b0;
            S_AXI_RDATA_OUT <= r_map ? {24'h00_0000, rbyte} : 32'h0000_0000;
            S_AXI_RRESP_OUT <= r_map ? ISGL_RESP_OKAY : ISGL_RESP_SLVERR;
        end
        else if (rvalid_q && S_AXI_RREADY_IN)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign S_AXI_ARREADY_OUT = arready_q;
    assign S_AXI_RVALID_OUT = rvalid_q;

    // ----------------------------------------------------------------
    // channel inputs
    // ----------------------------------------------------------------
    isgl_src_mux #(.DW(DW)) u_mux_a (
        .clk_in(REF_CLK_IN),
        .rstn_in(RSTN_IN),
        .sel_in(src_a_q),
        .first_in(first_s2_q),
        .second_in(second_s2_q),
        .test_in(test_q[DW-1:0]),
        .data_out(CHAN_A_DATA_OUT)
    );
    isgl_src_mux #(.DW(DW)) u_mux_b (
        .clk_in(REF_CLK_IN),
        .rstn_in(RSTN_IN),
        .sel_in(src_b_q),
        .first_in(first_s2_q),
        .second_in(second_s2_q),
        .test_in(test_q[DW-1:0]),
        .data_out(CHAN_B_DATA_OUT)
    );

    // ----------------------------------------------------------------
    // control outputs
    // ----------------------------------------------------------------
    wire force_exp = ctrl_q[ISGL_EXPONENT_FORCE_MAX_BIT];

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            EXP_A_OUT <= 4'h0;
            EXP_B_OUT <= 4'h0;
            INTEG_HOLD_OUT <= 1'b0;
            LOOP_SHIFT_OUT <= 2'h0;
            INIT_A_OUT <= 8'h00;
            INIT_B_OUT <= 8'h00;
            AMP_A_GAIN_OUT <= 3'h7;
            AMP_B_GAIN_OUT <= 3'h7;
        end
        else
        begin
            EXP_A_OUT <= force_exp ? ISGL_EXP_MAX : EXP_A_IN;
            EXP_B_OUT <= force_exp ? ISGL_EXP_MAX : EXP_B_IN;
            INTEG_HOLD_OUT <= ctrl_q[ISGL_HOLD_BIT];
            LOOP_SHIFT_OUT <= ctrl_q[ISGL_SHIFT_LSB +: 2];
            INIT_A_OUT <= gain_a_q;
            INIT_B_OUT <= gain_b_q;
            AMP_A_GAIN_OUT <= ~gain_a_q[7:5];
            AMP_B_GAIN_OUT <= ~gain_b_q[7:5];
        end
    end
endmodule : isgl_regs

/* logic/isgl_pkg.sv */
package isgl_pkg;
    // register indices (printed offsets); byte address is index * 4
    localparam logic [7:0] ISGL_IDX_SOURCE = 8'h13;
    localparam logic [7:0] ISGL_IDX_CTRL = 8'h14;
    localparam logic [7:0] ISGL_IDX_LEGACY_LO = 8'h15;
    localparam logic [7:0] ISGL_IDX_LEGACY_HI = 8'h16;
    localparam logic [7:0] ISGL_IDX_GAIN_A = 8'h17;
    localparam logic [7:0] ISGL_IDX_GAIN_B = 8'h18;
    localparam logic [7:0] ISGL_IDX_RB_A = 8'h19;
    localparam logic [7:0] ISGL_IDX_RB_B = 8'h1A;
    localparam logic [7:0] ISGL_IDX_TEST_LO = 8'h1B;
    localparam logic [7:0] ISGL_IDX_TEST_HI = 8'h1C;
    localparam int ISGL_ADDR_W = 10;
    // field positions
    localparam int ISGL_SRC_A_LSB = 0;
    localparam int ISGL_SRC_B_LSB = 2;
    localparam int ISGL_EXPONENT_FORCE_MAX_BIT = 0;
    localparam int ISGL_LEG_FORCE_BIT = 1;
    localparam int ISGL_LEG_RSTEN_BIT = 2;
    localparam int ISGL_HOLD_BIT = 3;
    localparam int ISGL_SHIFT_LSB = 4;
    // reset values
    localparam logic [1:0] ISGL_SRC_A_RST = 2'h0;
    localparam logic [1:0] ISGL_SRC_B_RST = 2'h1;
    localparam logic [7:0] ISGL_CTRL_RST = 8'h02;
    localparam logic [7:0] ISGL_BYTE_RST = 8'h00;
    localparam logic [13:0] ISGL_TEST_RST = 14'h0000;
    // source codes and forced exponent
    localparam logic [1:0] ISGL_SRC_FIRST = 2'h0;
    localparam logic [1:0] ISGL_SRC_SECOND = 2'h1;
    localparam logic [3:0] ISGL_EXP_MAX = 4'h7;
    // AXI responses
    localparam logic [1:0] ISGL_RESP_OKAY = 2'h0;
    localparam logic [1:0] ISGL_RESP_SLVERR = 2'h2;
endpackage : isgl_pkg

/* logic/isgl_src_mux.sv */
`timescale 1ns/1ps
module isgl_src_mux #(
    parameter int DW = 14
) (
    input wire logic clk_in, // clock
    input wire logic rstn_in, // async reset, active low
    input wire logic [1:0] sel_in, // source selector
    input wire logic [DW-1:0] first_in, // first input bus
    input wire logic [DW-1:0] second_in, // second input bus
    input wire logic [DW-1:0] test_in, // test value
    output logic [DW-1:0] data_out // registered selection
);
    logic [DW-1:0] mux_d;
    logic [DW-1:0] data_q;

    assign mux_d = (sel_in == 2'h0) ? first_in :
                   (sel_in == 2'h1) ? second_in : test_in;
    assign data_out = data_q;

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            data_q <= '0;
        else
            data_q <= mux_d;
    end
endmodule : isgl_src_mux

/* dv/isgl_regs_assertions.sv */
`timescale 1ns/1ps
module isgl_regs_chk
    import isgl_pkg::*;
#(
    parameter int IW = 8
) (
    input wire logic REF_CLK_IN, // clock
    input wire logic RSTN_IN, // reset, active low
    input wire logic [ISGL_ADDR_W-1:0] S_AXI_ARADDR_IN, // rd addr
    input wire logic S_AXI_ARVALID_IN, // rd addr valid
    input wire logic S_AXI_ARREADY_OUT, // rd addr ready
    input wire logic [31:0] S_AXI_RDATA_OUT, // rd data
    input wire logic S_AXI_RVALID_OUT, // rd valid
    input wire logic S_AXI_RREADY_IN, // rd ready
    input wire logic [3:0] EXP_A_IN, // computed exponent A
    input wire logic [3:0] EXP_A_OUT, // exponent out A
    input wire logic [3:0] EXP_B_OUT, // exponent out B
    input wire logic [IW-1:0] INTEG_A_IN, // integrator A
    input wire logic [IW-1:0] INTEG_B_IN, // integrator B
    input wire logic INTEG_UPD_IN, // integrator update
    input wire logic [7:0] INIT_A_OUT, // fixed gain A
    input wire logic [7:0] INIT_B_OUT, // fixed gain B
    input wire logic [2:0] AMP_A_GAIN_OUT, // amp code A
    input wire logic [2:0] AMP_B_GAIN_OUT // amp code B
);
    // ----------------------------------------
    // latched integrator values and properties
    // ----------------------------------------
    logic [IW-1:0] rb_a_q;
    logic [IW-1:0] rb_b_q;
    logic ar_go;
    assign ar_go = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            rb_a_q <= '0;
            rb_b_q <= '0;
        end
        else if (INTEG_UPD_IN)
        begin
            rb_a_q <= INTEG_A_IN;
            rb_b_q <= INTEG_B_IN;
        end
    end
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RSTN_IN);
    AST_AMP_A: assert property (
        AMP_A_GAIN_OUT == ~INIT_A_OUT[7:5])
        else $error("amp code A not inverted gain msbs");
    AST_AMP_B: assert property (
        AMP_B_GAIN_OUT == ~INIT_B_OUT[7:5])
        else $error("amp code B not inverted gain msbs");
    AST_EXP_A: assert property ($past(RSTN_IN) |->
        EXP_A_OUT == ISGL_EXP_MAX || EXP_A_OUT == $past(EXP_A_IN))
        else $error("exponent A neither forced nor passed");
    AST_EXP_B: assert property ($past(RSTN_IN) &&
        EXP_A_OUT != $past(EXP_A_IN) |-> EXP_B_OUT == ISGL_EXP_MAX)
        else $error("exponent B not forced with A");
    AST_RB_A: assert property (ar_go &&
        S_AXI_ARADDR_IN == {ISGL_IDX_RB_A, 2'b00} |=>
        S_AXI_RDATA_OUT == 32'($past(rb_a_q)))
        else $error("readback A wrong");
    AST_RB_B: assert property (ar_go &&
        S_AXI_ARADDR_IN == {ISGL_IDX_RB_B, 2'b00} |=>
        S_AXI_RDATA_OUT == 32'($past(rb_b_q)))
        else $error("readback B wrong");
    AST_R_NEXT: assert property (ar_go |=> S_AXI_RVALID_OUT)
        else $error("read answer late");
    AST_R_HOLD: assert property (
        S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
        |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
        else $error("read data not held");
    cover property (ar_go && S_AXI_ARADDR_IN == {ISGL_IDX_RB_A, 2'b00});
    cover property (EXP_A_OUT == ISGL_EXP_MAX && EXP_A_OUT != $past(EXP_A_IN));
    cover property (AMP_A_GAIN_OUT == 3'h0);
endmodule : isgl_regs_chk
bind isgl_regs isgl_regs_chk #(.IW(IW)) u_chk (.REF_CLK_IN(REF_CLK_IN),
    .RSTN_IN(RSTN_IN), .S_AXI_ARADDR_IN(S_AXI_ARADDR_IN),
    .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
    .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
    .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .EXP_A_IN(EXP_A_IN),
    .EXP_A_OUT(EXP_A_OUT), .EXP_B_OUT(EXP_B_OUT), .INTEG_A_IN(INTEG_A_IN),
    .INTEG_B_IN(INTEG_B_IN), .INTEG_UPD_IN(INTEG_UPD_IN),
    .INIT_A_OUT(INIT_A_OUT), .INIT_B_OUT(INIT_B_OUT),
    .AMP_A_GAIN_OUT(AMP_A_GAIN_OUT), .AMP_B_GAIN_OUT(AMP_B_GAIN_OUT));

/* dv/tb_input_select_gain_loop_control.sv */
`timescale 1ns/1ps
module tb_input_select_gain_loop_control;
    import isgl_pkg::*;
    // ----------------------------------------
    // stimulus, model and checks
    // ----------------------------------------
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] awaddr = '0;
    logic [9:0] araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic upd = 0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0, exp_a = '0, exp_b = '0;
    logic [13:0] first = '0, second = '0;
    logic [7:0] int_a = '0, int_b = '0;
    logic awready, wready, bvalid, arready, rvalid, hold;
    logic [1:0] bresp, rresp, shift, r;
    logic [31:0] rdata, d32;
    logic [13:0] cha, chb;
    logic [3:0] exa, exb;
    logic [7:0] ina, inb;
    logic [2:0] ampa, ampb;
    logic [7:0] mdl [8'h13:8'h1C];
    int error_cnt = 0;
    int checks = 0;
    always #50 clk = ~clk;
    isgl_regs uut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .S_AXI_AWADDR_IN(awaddr),
        .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb),
        .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
        .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .FIRST_INPUT_BUS_IN(first),
        .SECOND_INPUT_BUS_IN(second), .EXP_A_IN(exp_a), .EXP_B_IN(exp_b),
        .INTEG_A_IN(int_a), .INTEG_B_IN(int_b), .INTEG_UPD_IN(upd),
        .CHAN_A_DATA_OUT(cha), .CHAN_B_DATA_OUT(chb), .EXP_A_OUT(exa),
        .EXP_B_OUT(exb), .INTEG_HOLD_OUT(hold), .LOOP_SHIFT_OUT(shift),
        .INIT_A_OUT(ina), .INIT_B_OUT(inb), .AMP_A_GAIN_OUT(ampa),
        .AMP_B_GAIN_OUT(ampb));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // address and data are each released at the edge after their ready is seen high, bready at the edge after bvalid is
    task automatic axw(input logic [9:0] a, input logic [7:0] v,
        input logic [3:0] s, output logic [1:0] rs);
        bit aw = 1, w = 1, b = 1;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && b; n++)
        begin
            @(negedge clk);
            aw = aw && !awready;
            w = w && !wready;
            b = !bvalid;
            rs = bresp;
            @(posedge clk);
            awvalid <= aw;
            wvalid <= w;
            bready <= b;
        end
        if (b) error_cnt++;
    endtask : axw
    task automatic axr(input logic [9:0] a, output logic [31:0] v,
        output logic [1:0] rs);
        bit ar = 1, rv = 1;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && rv; n++)
        begin
            @(negedge clk);
            ar = ar && !arready;
            rv = !rvalid;
            v = rdata;
            rs = rresp;
            @(posedge clk);
            arvalid <= ar;
            rready <= rv;
        end
        if (rv) error_cnt++;
    endtask : axr
    function automatic logic [7:0] msk(input logic [7:0] i);
        case (i)
            8'h13: return 8'h0F;
            8'h14, 8'h1C: return 8'h3F;
            8'h19, 8'h1A: return 8'h00;
            default: return 8'hFF;
        endcase
    endfunction : msk
    function automatic logic [13:0] src(input logic [1:0] s);
        case (s)
            2'h0: return first;
            2'h1: return second;
            default: return {mdl[8'h1C][5:0], mdl[8'h1B]};
        endcase
    endfunction : src
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        axw({i, 2'b00}, v, 4'hF, r);
        chk(32'(r), 32'(ISGL_RESP_OKAY));
        mdl[i] = (mdl[i] & ~msk(i)) | (v & msk(i));
    endtask : wr
    task automatic rd(input logic [7:0] i);
        axr({i, 2'b00}, d32, r);
        chk(32'(r), 32'(ISGL_RESP_OKAY));
        chk(d32, 32'(mdl[i]));
    endtask : rd
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end
    initial
    begin
        void'($urandom(32'h9E2A4488));
        for (int i = 8'h13; i <= 8'h1C; i++) mdl[i] = 8'h00;
        mdl[8'h13] = 8'h04;
        mdl[8'h14] = ISGL_CTRL_RST;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 8'h13; i <= 8'h1C; i++)
            if (i != 8'h15 && i != 8'h16) rd(8'(i));
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h17, k == 0 ? 8'hFF : 8'($urandom));
            wr(8'h18, 8'($urandom));
            @(negedge clk);
            chk(32'(ampa), 32'(mdl[8'h17][7:5] ^ 3'h7));
            chk(32'(ampb), 32'(mdl[8'h18][7:5] ^ 3'h7));
            chk(32'(ina), 32'(mdl[8'h17]));
            chk(32'(inb), 32'(mdl[8'h18]));
        end
        for (int k = 0; k < 8; k++)
        begin
            wr(8'h14, {2'b00, k[1:0], k[0], 2'b01, k[2]});
            exp_a <= 4'($urandom);
            exp_b <= 4'($urandom);
            @(posedge clk);
            @(negedge clk);
            chk(32'(hold), 32'(k[0]));
            chk(32'(shift), 32'(k[1:0]));
            chk(32'(exa), 32'(k[2] ? ISGL_EXP_MAX : exp_a));
            chk(32'(exb), 32'(k[2] ? ISGL_EXP_MAX : exp_b));
            rd(8'h14);
        end
        wr(8'h1B, 8'($urandom));
        wr(8'h1C, 8'($urandom));
        rd(8'h1C);
        for (int s = 0; s < 16; s++)
        begin
            @(posedge clk);
            first <= 14'($urandom);
            second <= 14'($urandom);
            wr(8'h13, 8'(s));
            @(posedge clk);
            @(negedge clk);
            chk(32'(cha), 32'(src(s[1:0])));
            chk(32'(chb), 32'(src(s[3:2])));
        end
        for (int k = 0; k < 4; k++)
        begin
            int_a <= 8'($urandom);
            int_b <= 8'($urandom);
            upd <= 1'b1;
            @(posedge clk);
            upd <= 1'b0;
            mdl[8'h19] = int_a;
            mdl[8'h1A] = int_b;
            int_a <= ~int_a;
            wr(8'h19, 8'hA5);
            rd(8'h19);
            rd(8'h1A);
        end
        axr(10'h000, d32, r);
        chk(32'(r), 32'(ISGL_RESP_SLVERR));
        chk(d32, 32'h0);
        axw(10'h05D, 8'h3C, 4'hF, r);
        chk(32'(r), 32'(ISGL_RESP_SLVERR));
        axw(10'h05C, 8'h5A, 4'hE, r);
        chk(32'(r), 32'(ISGL_RESP_OKAY));
        rd(8'h17);
        results();
    end
endmodule : tb_input_select_gain_loop_control
